// ---- hw/ctrl_cfg_pkg.sv ----
package ctrl_cfg_pkg;

  // Register indices (byte address = 4 * index)
  localparam logic [7:0] CFG_IDX     = 8'h00;
  localparam logic [7:0] STATUS_IDX  = 8'h01;
  localparam logic [7:0] ADM_ATTR_IDX = 8'h02;
  localparam logic [7:0] ADM_SQB_IDX  = 8'h03;
  localparam logic [7:0] ADM_CQB_IDX  = 8'h04;
  localparam logic [7:0] FEAT_IDX    = 8'h05;
  localparam logic [7:0] CAPS_IDX    = 8'h06;
  localparam logic [7:0] QCTL_IDX    = 8'h07;

  // Field positions in the configuration word
  localparam int EN_BIT   = 0;
  localparam int CMDSET_LSB = 4;
  localparam int PAGE_LSB   = 7;
  localparam int ARB_LSB    = 11;

  // Reset values
  localparam logic [2:0]  ARB_RST    = 3'h0;
  localparam logic [3:0]  PAGE_RST   = 4'h0;
  localparam logic [2:0]  CMDSET_RST = 3'h0;
  localparam logic [31:0] FEAT_RST = 32'h0000_0000;

  // Arbitration codes
  localparam logic [2:0] ARB_RR     = 3'h0;
  localparam logic [2:0] ARB_WRR    = 3'h1;
  localparam logic [2:0] ARB_VENDOR = 3'h7;

  // Page size: 2^(12+code) bytes
  localparam int PAGE_BASE_SHIFT = 12;
  localparam logic [4:0] PAGE_BASE_SHIFT_W = 5'h0c;

  // Shutdown state codes
  localparam logic [1:0] SHUT_NORMAL = 2'h0;
  localparam logic [1:0] SHUT_BUSY   = 2'h1;
  localparam logic [1:0] SHUT_DONE   = 2'h2;

  // Cycles from enable to ready
  localparam int          READY_DELAY_NS     = 200;
  localparam int          CLK_PERIOD_NS      = 25;
  localparam int          READY_DELAY_CYC    = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  READY_DELAY_CYC_W  = 4'(READY_DELAY_CYC);

  typedef struct packed {
    logic [2:0] arb;
    logic [3:0] page_code;
    logic [2:0] cmd_set;
    logic       enable;
  } ctrl_cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_RESET = 4'b1000
  } ctrl_state_e;

endpackage

// ---- hw/ctrl_reg_word.sv ----
`timescale 1ns/10ps
`default_nettype none
// Software-written word preserved or cleared by controller reset
module ctrl_reg_word
  import ctrl_cfg_pkg::*;
#(
  parameter logic [31:0] RST_VAL  = 32'h0000_0000,
  parameter bit          CTRL_CLR = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic        ctrl_rst,
  output logic [31:0]      value_q
);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      value_q <= RST_VAL;
    end else if (wr_en) begin
      value_q <= wr_data;
    end else if (CTRL_CLR && ctrl_rst) begin
      value_q <= RST_VAL;
    end
  end

endmodule
`default_nettype wire

// ---- hw/controller_config_enable.sv ----
`timescale 1ns/10ps
`default_nettype none
module controller_config_enable
  import ctrl_cfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        core_ready,
  input  wire logic        shutdown_req,
  input  wire logic        shutdown_done,
  input  wire logic        core_idle,
  input  wire logic        posted_flush_done,
  output logic             cmd_fetch_en,
  output logic             cpl_post_en,
  output logic             ctrl_reset,
  output logic             io_queue_clear,
  output logic             admin_queue_reinit,
  output logic             flush_posted,
  output logic [2:0]       arb_sel,
  output logic [2:0]       io_cmd_set,
  output logic [4:0]       page_shift,
  output logic             ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields

  ctrl_cfg_s   cfg_q;
  ctrl_state_e state_q;
  ctrl_state_e state_d;
  logic        cfg_wr;
  logic        en_fall;
  logic        ctrl_rst_pulse;
  logic [1:0]  shut_q;
  logic [3:0]  rdy_cnt_q;
  logic [31:0] feat_q;
  logic [31:0] adm_attr_q;
  logic [31:0] adm_sqb_q;
  logic [31:0] adm_cqb_q;
  logic        adm_attr_wr;
  logic        adm_sqb_wr;
  logic        adm_cqb_wr;
  logic        feat_wr;
  logic [31:0] cfg_rd_word;
  logic [31:0] status_rd_word;

  assign cfg_wr  = reg_wr && (reg_addr == CFG_IDX);
  assign en_fall = cfg_wr && cfg_q.enable && !reg_wdata[EN_BIT];
  assign ctrl_rst_pulse = en_fall;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_q.arb       <= ARB_RST;
      cfg_q.page_code <= PAGE_RST;
      cfg_q.cmd_set   <= CMDSET_RST;
      cfg_q.enable    <= 1'b0;
    end else if (cfg_wr) begin
      cfg_q.enable <= reg_wdata[EN_BIT];
      // Fields lock while enabled; software must disable first
      if (!cfg_q.enable) begin
        cfg_q.arb       <= reg_wdata[ARB_LSB +: 3];
        cfg_q.page_code <= reg_wdata[PAGE_LSB +: 4];
        cfg_q.cmd_set   <= reg_wdata[CMDSET_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode for the side registers

  // Status, capability and state indices are read only: no strobe reaches them
  assign adm_attr_wr = reg_wr && (reg_addr == ADM_ATTR_IDX);
  assign adm_sqb_wr  = reg_wr && (reg_addr == ADM_SQB_IDX);
  assign adm_cqb_wr  = reg_wr && (reg_addr == ADM_CQB_IDX);
  assign feat_wr     = reg_wr && (reg_addr == FEAT_IDX);

  ////////////////////////////////////////////////////////////////////////////
  // Controller state

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cfg_q.enable) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        // Dropping enable before RUN skips the reset sequence
        if (!cfg_q.enable) begin
          state_d = ST_IDLE;
        end else if (core_ready && rdy_cnt_q == READY_DELAY_CYC_W) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ctrl_rst_pulse || !cfg_q.enable) begin
          state_d = ST_RESET;
        end
      end
      ST_RESET: begin
        // Hold until posted data is safe and core went idle
        if (posted_flush_done && core_idle) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Saturates so a late core_ready still finds the wait done
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdy_cnt_q <= 4'h0;
    end else if (state_q != ST_START) begin
      rdy_cnt_q <= 4'h0;
    end else if (rdy_cnt_q != READY_DELAY_CYC_W) begin
      rdy_cnt_q <= rdy_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown state

  // Reported only; the shutdown work itself runs in the core
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      shut_q <= SHUT_NORMAL;
    end else if (ctrl_rst_pulse) begin
      shut_q <= SHUT_NORMAL;
    end else if (shut_q == SHUT_BUSY && shutdown_done) begin
      shut_q <= SHUT_DONE;
    end else if (shut_q == SHUT_NORMAL && shutdown_req) begin
      shut_q <= SHUT_BUSY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Other registers: admin queue words survive, features reset

  ctrl_reg_word #(.RST_VAL(32'h0000_0000), .CTRL_CLR(1'b0)) u_adm_attr (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .wr_en    (adm_attr_wr),
    .wr_data  (reg_wdata),
    .ctrl_rst (ctrl_rst_pulse),
    .value_q  (adm_attr_q)
  );

  ctrl_reg_word #(.RST_VAL(32'h0000_0000), .CTRL_CLR(1'b0)) u_adm_sqb (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .wr_en    (adm_sqb_wr),
    .wr_data  (reg_wdata),
    .ctrl_rst (ctrl_rst_pulse),
    .value_q  (adm_sqb_q)
  );

  ctrl_reg_word #(.RST_VAL(32'h0000_0000), .CTRL_CLR(1'b0)) u_adm_cqb (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .wr_en    (adm_cqb_wr),
    .wr_data  (reg_wdata),
    .ctrl_rst (ctrl_rst_pulse),
    .value_q  (adm_cqb_q)
  );

  ctrl_reg_word #(.RST_VAL(FEAT_RST), .CTRL_CLR(1'b1)) u_feat (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .wr_en    (feat_wr),
    .wr_data  (reg_wdata),
    .ctrl_rst (ctrl_rst_pulse),
    .value_q  (feat_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the controller core

  // Taken from the next state so the core sees RUN on the same edge as ready, except when enable drops on the START-to-RUN cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cmd_fetch_en <= 1'b0;
    end else begin
      cmd_fetch_en <= (state_d == ST_RUN);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cpl_post_en <= 1'b0;
    end else begin
      cpl_post_en <= (state_d == ST_RUN);
    end
  end

  // Queue clear also fires on an enable drop that skips the RESET state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_reset         <= 1'b0;
      io_queue_clear     <= 1'b0;
      admin_queue_reinit <= 1'b0;
      flush_posted       <= 1'b0;
    end else begin
      ctrl_reset         <= (state_d == ST_RESET);
      io_queue_clear     <= ctrl_rst_pulse || (state_d == ST_RESET);
      admin_queue_reinit <= ctrl_rst_pulse;
      flush_posted       <= (state_d == ST_RESET);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ready <= 1'b0;
    end else begin
      ready <= (state_d == ST_RUN) && !ctrl_rst_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field outputs

  // A single latched set feeds every I/O queue, so sets cannot mix
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      arb_sel <= ARB_RST;
    end else begin
      arb_sel <= cfg_q.arb;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      io_cmd_set <= CMDSET_RST;
    end else begin
      io_cmd_set <= cfg_q.cmd_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      page_shift <= PAGE_BASE_SHIFT_W;
    end else begin
      page_shift <= PAGE_BASE_SHIFT_W + {1'b0, cfg_q.page_code};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after strobe

  assign cfg_rd_word    = {18'h0, cfg_q.arb, cfg_q.page_code, cfg_q.cmd_set,
                           3'h0, cfg_q.enable};
  assign status_rd_word = {28'h0, shut_q, 1'b0, ready};

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        CFG_IDX:      reg_rdata <= cfg_rd_word;
        STATUS_IDX:   reg_rdata <= status_rd_word;
        ADM_ATTR_IDX: reg_rdata <= adm_attr_q;
        ADM_SQB_IDX:  reg_rdata <= adm_sqb_q;
        ADM_CQB_IDX:  reg_rdata <= adm_cqb_q;
        FEAT_IDX:     reg_rdata <= feat_q;
        QCTL_IDX:     reg_rdata <= {28'h0, state_q};
        // Capability index holds no storage here and reads zero
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ---- bench/controller_config_enable_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module controller_config_enable_checker
  import ctrl_cfg_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        cmd_fetch_en,
  input wire logic        cpl_post_en,
  input wire logic        ctrl_reset,
  input wire logic        io_queue_clear,
  input wire logic        admin_queue_reinit,
  input wire logic        flush_posted,
  input wire logic [2:0]  arb_sel,
  input wire logic [2:0]  io_cmd_set,
  input wire logic [4:0]  page_shift,
  input wire logic        ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_post_fetch: assert property (cpl_post_en == cmd_fetch_en)
    else $error("completion posting differs from fetch");
  chk_page_range: assert property (page_shift >= 5'h0c && page_shift <= 5'h1b)
    else $error("page shift out of range");
  chk_ready_drop: assert property (
    reg_wr && reg_addr == 8'h00 && !reg_wdata[0] && ready |=> ##[0:1] !ready && ctrl_reset)
    else $error("ready held after enable cleared");
  chk_reinit_pulse: assert property (admin_queue_reinit |=> !admin_queue_reinit)
    else $error("admin reinit longer than one cycle");
  chk_reset_idle: assert property (ctrl_reset |-> !cmd_fetch_en && !ready)
    else $error("processing during controller reset");
  chk_flush_rst: assert property (flush_posted |-> ctrl_reset && io_queue_clear)
    else $error("flush outside controller reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_field_lock: assert property (cmd_fetch_en && $past(cmd_fetch_en)
    |-> $stable(arb_sel) && $stable(io_cmd_set) && $stable(page_shift))
    else $error("fields changed while enabled");
  chk_run_ready: assert property ($rose(cmd_fetch_en) |-> ready)
    else $error("fetch without ready");
  cov_run: cover property ($rose(cmd_fetch_en));
  cov_reset: cover property (admin_queue_reinit);
  cov_leave: cover property ($fell(ctrl_reset));
endmodule

bind controller_config_enable controller_config_enable_checker chk_u (.*);
`default_nettype wire

// ---- bench/controller_config_enable_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module controller_config_enable_tb;
  import ctrl_cfg_pkg::*;
  typedef struct packed {
    logic [31:0] w;
    logic [2:0]  a;
    logic [2:0]  c;
    logic [4:0]  s;
  } row_s;
  logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic core_ready = 0, shutdown_req = 0, shutdown_done = 0;
  logic core_idle = 0, posted_flush_done = 0;
  logic cmd_fetch_en, cpl_post_en, ctrl_reset, io_queue_clear;
  logic admin_queue_reinit, flush_posted, ready;
  logic [2:0] arb_sel, io_cmd_set;
  logic [4:0] page_shift;
  int bad_count = 0, num_checks = 0, cyc = 0, n;
  row_s rows [4] = '{'{32'h0, 3'h0, 3'h0, 5'h0c}, '{32'h3ff0, 3'h7, 3'h7, 5'h1b},
                     '{32'h0890, 3'h1, 3'h1, 5'h0d}, '{32'hffff_c00e, 3'h0, 3'h0, 5'h0c}};

  controller_config_enable dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_ready(core_ready), .shutdown_req(shutdown_req), .shutdown_done(shutdown_done),
    .core_idle(core_idle), .posted_flush_done(posted_flush_done),
    .cmd_fetch_en(cmd_fetch_en), .cpl_post_en(cpl_post_en), .ctrl_reset(ctrl_reset),
    .io_queue_clear(io_queue_clear), .admin_queue_reinit(admin_queue_reinit),
    .flush_posted(flush_posted), .arb_sel(arb_sel), .io_cmd_set(io_cmd_set),
    .page_shift(page_shift), .ready(ready));

  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task print_verdict;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1;
    tick(1);
    chk(page_shift, 5'h0c);
    foreach (rows[i]) begin
      // Written while disabled: code and page limits, plus reserved bits that must be ignored
      wr(CFG_IDX, rows[i].w);
      rd(CFG_IDX);
      chk(d, rows[i].w & 32'h3ff0);
      tick(2);
      chk(arb_sel, rows[i].a);
      chk(io_cmd_set, rows[i].c);
      chk(page_shift, rows[i].s);
    end
    // Enable with fields in the same write
    core_ready <= 1;
    wr(CFG_IDX, 32'h0891);
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n >= 8 && n < 40, 1);
    chk({cmd_fetch_en, cpl_post_en}, 2'b11);
    wr(CFG_IDX, 32'h3ff1);
    rd(CFG_IDX);
    chk(d, 32'h0891);
    tick(3);
    chk({arb_sel, io_cmd_set, page_shift}, {3'h1, 3'h1, 5'h0d});
    wr(ADM_ATTR_IDX, 32'h1234);
    wr(FEAT_IDX, 32'h55);
    @(posedge clk_sys) shutdown_req <= 1;
    @(posedge clk_sys) shutdown_req <= 0;
    rd(STATUS_IDX);
    chk(d, 32'h5);
    @(posedge clk_sys) shutdown_done <= 1;
    @(posedge clk_sys) shutdown_done <= 0;
    rd(STATUS_IDX);
    chk(d, 32'h9);
    // Drop enable while flush still pending
    wr(CFG_IDX, 32'h0);
    #1 chk(admin_queue_reinit, 1);
    tick(2);
    chk({ctrl_reset, io_queue_clear, flush_posted, ready}, 4'b1110);
    tick(4);
    chk(ctrl_reset, 1);
    @(posedge clk_sys);
    posted_flush_done <= 1; core_idle <= 1;
    tick(3);
    chk({ctrl_reset, cmd_fetch_en}, 2'b00);
    rd(ADM_ATTR_IDX);
    chk(d, 32'h1234);
    rd(FEAT_IDX);
    chk(d, 32'h0);
    rd(STATUS_IDX);
    chk(d, 32'h0);
    rd(CAPS_IDX);
    chk(d, 32'h0);
    rd(8'h20);
    chk(d, 32'h0);
    rd(QCTL_IDX);
    chk(d, 32'h1);
    // Second system reset while disabled, after non-reset fields are written
    wr(CFG_IDX, 32'h3ff0);
    tick(3);
    rst_b <= 0;
    tick(2);
    rst_b <= 1;
    tick(1);
    chk({arb_sel, io_cmd_set, page_shift}, {3'h0, 3'h0, 5'h0c});
    print_verdict;
  end
endmodule
`default_nettype wire
